// ---- src/cpu_control_register_file.sv ----
// Control registers of the 8-bit core: instruction pointer, flag word,
// stack pointer, general registers and address-region decode.
// Assumes the execution unit drives commands and memory answers in one cycle.
//
// Behaviour
// - 0040h..007Fh holds table-call entry addresses
// - High-speed RAM is data and stack memory
// - High-speed RAM ends FEFFh, 128/256/512 bytes
// - 16-bit instruction pointer holds next address
// - Pointer advances by length or loads branch
// - Reset loads pointer from vector 0000h/0001h
// - Vector low byte even, high byte odd
// - Flag word layout, bit1 one, 5/3/2 zero
// - Reset sets flag word to 02h
// - Flags saved on interrupt/push, restored on return/pop
// - Accept flag clear blocks maskable interrupts
// - Accept flag: clear on disable/ack, set enable
// - Zero flag follows zero result
// - Half-carry follows bit-3 carry or borrow
// - Carry records overflow, shift-out, bit accumulator
// - 16-bit stack pointer, high-speed RAM only
// - Pre-decrement on push, post-increment on pop
// - Eight byte registers pairing into four pairs
// - Peripheral window FF00h..FFFFh
// - Peripheral accesses limited to defined widths
`timescale 1ns/1ps
`default_nettype none
module cpu_control_register_file
   import cpu_regs_pkg::*;
#(
   parameter int HRAM_BYTES = HRAM_BYTES_DEFAULT
)(
   input wire logic clk_in,
   input wire logic resetn_in,
   // Instruction pointer control
   input wire ip_cmd_t ip_cmd_in,
   input wire logic [2:0] ip_len_in,
   input wire logic [15:0] ip_load_in,
   input wire logic [4:0] tcall_idx_in,
   // Memory read port used by vector fetch
   output logic mem_rd_out,
   output logic [15:0] mem_addr_out,
   input wire logic [7:0] mem_rdata_in,
   // Flags
   input wire flag_upd_t flag_upd_in,
   input wire logic irq_ack_in,
   input wire logic irq_pending_in,
   input wire logic irq_nmi_in,
   // Stack pointer
   input wire sp_cmd_t sp_cmd_in,
   input wire logic [15:0] sp_load_in,
   // General registers
   input wire gpr_wr_t gpr_wr_in,
   input wire logic [2:0] gpr_rd8_idx_in,
   input wire logic [1:0] gpr_rd16_idx_in,
   // Region check of an operand access
   input wire logic [15:0] acc_addr_in,
   input wire logic [1:0] acc_width_in,
   input wire logic [2:0] periph_width_ok_in,
   // Register state
   output logic [15:0] next_instr_pointer_out,
   output logic [7:0] status_flag_word_out,
   output logic [15:0] stack_top_pointer_out,
   output logic [15:0] stack_addr_out,
   output logic sp_fault_out,
   output logic irq_take_out,
   output logic [7:0] gpr_rd8_out,
   output logic [15:0] gpr_rd16_out,
   output region_t acc_region_out,
   output logic acc_refused_out,
   output logic ready_out
);
   typedef enum logic [1:0] {
      VEC_LO = 2'b00,
      VEC_HI = 2'b01,
      RUN = 2'b10
   } boot_state_t;

   localparam logic [15:0] HRAM_FIRST = HRAM_LAST - 16'(HRAM_BYTES) + 16'h0001;

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [7:0] fix_flags(input logic [7:0] w);
      return (w & ~FLAG_FIXED_MASK) | FLAG_FIXED_VAL;
   endfunction

   boot_state_t boot_q, boot_d;
   logic [15:0] ip_q, ip_d;
   logic [7:0] vec_lo_q;
   logic [7:0] flags_q, flags_d;
   logic [15:0] sp_q, sp_d;
   logic [15:0] stack_addr_q, stack_addr_d;
   logic sp_fault_q, irq_take_q, mem_rd_q, refused_q, ready_q;
   logic [15:0] mem_addr_q;
   logic [7:0] gpr8_q;
   logic [15:0] gpr16_q;
   region_t region_q;
   logic [7:0] gpr8_w;
   logic [15:0] gpr16_w;

   ////////////////////////////////////////////////////////////////////////////
   // Boot sequence and instruction pointer

   wire run_w = (boot_q == RUN);
   // Table entry n sits at 0040h + 2n
   wire [15:0] tcall_addr_w = TCALL_BASE + {10'h000, tcall_idx_in, 1'b0};

   always_comb begin
      boot_d = boot_q;
      ip_d = ip_q;
      case (boot_q)
         VEC_LO: boot_d = VEC_HI;
         VEC_HI: begin
            boot_d = RUN;
            ip_d = {mem_rdata_in, vec_lo_q};
         end
         RUN: begin
            case (ip_cmd_in)
               IP_ADVANCE: ip_d = ip_q + {13'h0000, ip_len_in};
               IP_LOAD: ip_d = ip_load_in;
               IP_TABLE: ip_d = ip_load_in;
               default: ip_d = ip_q;
            endcase
         end
         default: boot_d = VEC_LO;
      endcase
   end

   // Address is taken from the next state, so once registered it arrives with the state that samples its byte
   wire [15:0] mem_addr_w = (boot_d == VEC_HI) ? VEC_RESET_HI : tcall_addr_w;
   wire mem_rd_w = (boot_d == VEC_HI) || (run_w && (ip_cmd_in == IP_TABLE));

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         boot_q <= VEC_LO;
         ip_q <= 16'h0000;
         vec_lo_q <= 8'h00;
         // Low vector byte is already shown while reset is held
         mem_rd_q <= 1'b1;
         mem_addr_q <= VEC_RESET_LO;
         ready_q <= 1'b0;
      end else begin
         boot_q <= boot_d;
         ip_q <= ip_d;
         mem_rd_q <= mem_rd_w;
         mem_addr_q <= mem_addr_w;
         ready_q <= (boot_d == RUN);
         if (boot_q == VEC_LO) vec_lo_q <= mem_rdata_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flag word

   always_comb begin
      flags_d = flags_q;
      if (flag_upd_in.word_we) flags_d = flag_upd_in.word_val;
      if (flag_upd_in.z_we) flags_d[FLAG_Z_BIT] = flag_upd_in.z_val;
      if (flag_upd_in.ac_we) flags_d[FLAG_AC_BIT] = flag_upd_in.ac_val;
      if (flag_upd_in.cy_we) flags_d[FLAG_CY_BIT] = flag_upd_in.cy_val;
      if (flag_upd_in.ei_op) flags_d[FLAG_IE_BIT] = 1'b1;
      // Acknowledge wins over enable so a taken interrupt cannot re-nest
      if (flag_upd_in.di_op || irq_ack_in) flags_d[FLAG_IE_BIT] = 1'b0;
      flags_d = fix_flags(flags_d);
   end

   // Non-maskable sources pass regardless of the accept flag
   wire irq_take_w = irq_nmi_in || (irq_pending_in && flags_q[FLAG_IE_BIT]);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         flags_q <= FLAG_RESET;
         irq_take_q <= 1'b0;
      end else begin
         if (run_w) flags_q <= flags_d;
         irq_take_q <= run_w && irq_take_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stack pointer

   wire [15:0] sp_dec_w = sp_q - 16'h0001;
   always_comb begin
      sp_d = sp_q;
      stack_addr_d = stack_addr_q;
      case (sp_cmd_in)
         SP_PUSH: begin
            sp_d = sp_dec_w;
            stack_addr_d = sp_dec_w;
         end
         SP_POP: begin
            sp_d = sp_q + 16'h0001;
            stack_addr_d = sp_q;
         end
         SP_LOAD: sp_d = sp_load_in;
         default: sp_d = sp_q;
      endcase
   end

   // Reset value is 0000h, outside high-speed RAM; software must load it first
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sp_q <= 16'h0000;
         stack_addr_q <= 16'h0000;
         sp_fault_q <= 1'b0;
      end else if (run_w) begin
         sp_q <= sp_d;
         stack_addr_q <= stack_addr_d;
         // A load is no stack access, so it leaves no fault behind
         sp_fault_q <= !in_range(stack_addr_d, HRAM_FIRST, HRAM_LAST) &&
                       ((sp_cmd_in == SP_PUSH) || (sp_cmd_in == SP_POP));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // General registers and region decode

   gpr_bank u_gpr (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .wr_in(gpr_wr_in),
      .rd8_idx_in(gpr_rd8_idx_in),
      .rd16_idx_in(gpr_rd16_idx_in),
      .rd8_out(gpr8_w),
      .rd16_out(gpr16_w)
   );

   wire in_tcall_w = in_range(acc_addr_in, TCALL_BASE, TCALL_LAST);
   wire in_hram_w = in_range(acc_addr_in, HRAM_FIRST, HRAM_LAST);
   wire in_periph_w = in_range(acc_addr_in, PERIPH_BASE, PERIPH_LAST);
   region_t region_w;
   assign region_w = {in_tcall_w, in_hram_w, in_periph_w};
   // Width codes 0/1/2 mean 1/8/16 bits; odd 16-bit peripheral access refused
   wire width_bad_w = (acc_width_in == 2'd3) || !periph_width_ok_in[acc_width_in];
   wire odd16_w = (acc_width_in == 2'd2) && acc_addr_in[0];
   wire refused_w = region_w.periph && (width_bad_w || odd16_w);

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         gpr8_q <= 8'h00;
         gpr16_q <= 16'h0000;
         region_q <= '0;
         refused_q <= 1'b0;
      end else begin
         gpr8_q <= gpr8_w;
         gpr16_q <= gpr16_w;
         region_q <= region_w;
         refused_q <= refused_w;
      end
   end

   assign next_instr_pointer_out = ip_q;
   assign status_flag_word_out = flags_q;
   assign stack_top_pointer_out = sp_q;
   assign stack_addr_out = stack_addr_q;
   assign sp_fault_out = sp_fault_q;
   assign irq_take_out = irq_take_q;
   assign mem_rd_out = mem_rd_q;
   assign mem_addr_out = mem_addr_q;
   assign gpr_rd8_out = gpr8_q;
   assign gpr_rd16_out = gpr16_q;
   assign acc_region_out = region_q;
   assign acc_refused_out = refused_q;
   assign ready_out = ready_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_boot_done;
      boot_q == VEC_HI ##1 boot_q == RUN;
   endsequence
   property p_vec_load;
      @(posedge clk_in) disable iff (!resetn_in)
      (boot_q == VEC_HI) |=> (ip_q == {$past(mem_rdata_in), $past(vec_lo_q)});
   endproperty
   a_vec_load: assert property (p_vec_load) else $error("vector not loaded");
   property p_boot_len;
      @(posedge clk_in) disable iff (!resetn_in)
      $rose(resetn_in) |-> ##1 s_boot_done;
   endproperty
   a_boot_len: assert property (p_boot_len) else $error("boot length wrong");
   property p_fixed;
      @(posedge clk_in) disable iff (!resetn_in)
      (flags_q & FLAG_FIXED_MASK) == FLAG_FIXED_VAL;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed flag bits wrong");
   property p_ack_clear;
      @(posedge clk_in) disable iff (!resetn_in)
      (run_w && irq_ack_in) |=> !flags_q[FLAG_IE_BIT];
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("accept flag kept");
   property p_mask;
      @(posedge clk_in) disable iff (!resetn_in)
      (!flags_q[FLAG_IE_BIT] && !irq_nmi_in) |=> !irq_take_q;
   endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt taken");
   property p_push;
      @(posedge clk_in) disable iff (!resetn_in)
      (run_w && sp_cmd_in == SP_PUSH) |=> (sp_q == $past(sp_q) - 16'h0001) && (stack_addr_q == sp_q);
   endproperty
   a_push: assert property (p_push) else $error("push not pre-decrement");
   property p_pop;
      @(posedge clk_in) disable iff (!resetn_in)
      (run_w && sp_cmd_in == SP_POP) |=> (stack_addr_q == $past(sp_q)) && (sp_q == stack_addr_q + 16'h0001);
   endproperty
   a_pop: assert property (p_pop) else $error("pop not post-increment");
   property p_advance;
      @(posedge clk_in) disable iff (!resetn_in)
      (run_w && ip_cmd_in == IP_ADVANCE) |=> ip_q == $past(ip_q) + {13'h0000, $past(ip_len_in)};
   endproperty
   a_advance: assert property (p_advance) else $error("pointer advance wrong");
   property p_odd16;
      @(posedge clk_in) disable iff (!resetn_in)
      (region_w.periph && odd16_w) |=> acc_refused_out;
   endproperty
   a_odd16: assert property (p_odd16) else $error("odd word access passed");
endmodule // cpu_control_register_file
`default_nettype wire

// ---- src/cpu_regs_pkg.sv ----
// Package for the core register file: memory map, flag layout, reset values,
// command encodings and the packed carriers shared by the register file.
// Assumes byte-wide memory with a 16-bit address space.
package cpu_regs_pkg;

   localparam logic [15:0] VEC_RESET_LO = 16'h0000;
   localparam logic [15:0] VEC_RESET_HI = 16'h0001;
   localparam logic [15:0] TCALL_BASE = 16'h0040;
   localparam logic [15:0] TCALL_LAST = 16'h007f;
   localparam logic [15:0] HRAM_LAST = 16'hfeff;
   localparam logic [15:0] PERIPH_BASE = 16'hff00;
   localparam logic [15:0] PERIPH_LAST = 16'hffff;
   localparam int HRAM_BYTES_DEFAULT = 512;

   localparam int FLAG_IE_BIT = 7;
   localparam int FLAG_Z_BIT = 6;
   localparam int FLAG_AC_BIT = 4;
   localparam int FLAG_CY_BIT = 0;
   localparam logic [7:0] FLAG_FIXED_MASK = 8'h2e;
   localparam logic [7:0] FLAG_FIXED_VAL = 8'h02;
   localparam logic [7:0] FLAG_RESET = 8'h02;

   // Instruction pointer commands from the execution unit
   typedef enum logic [2:0] {
      IP_HOLD = 3'b000,
      IP_ADVANCE = 3'b001,
      IP_LOAD = 3'b010,
      IP_TABLE = 3'b011
   } ip_cmd_t;

   // Stack pointer commands, one byte per command
   typedef enum logic [1:0] {
      SP_HOLD = 2'b00,
      SP_PUSH = 2'b01,
      SP_POP = 2'b10,
      SP_LOAD = 2'b11
   } sp_cmd_t;

   // Flag word update from one executed instruction
   typedef struct packed {
      logic z_we;
      logic z_val;
      logic ac_we;
      logic ac_val;
      logic cy_we;
      logic cy_val;
      logic di_op;
      logic ei_op;
      logic word_we;
      logic [7:0] word_val;
   } flag_upd_t;

   // General register port: 8-bit by index or 16-bit by pair
   typedef struct packed {
      logic we8;
      logic [2:0] idx8;
      logic [7:0] d8;
      logic we16;
      logic [1:0] idx16;
      logic [15:0] d16;
   } gpr_wr_t;

   // Memory region classification of an address
   typedef struct packed {
      logic tcall;
      logic hram;
      logic periph;
   } region_t;

endpackage

// ---- src/gpr_bank.sv ----
// Eight byte registers that also read and write as four 16-bit pairs.
// Assumes one write port, in-order writes from the execution unit.
`timescale 1ns/1ps
`default_nettype none
module gpr_bank
   import cpu_regs_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire gpr_wr_t wr_in,
   input wire logic [2:0] rd8_idx_in,
   input wire logic [1:0] rd16_idx_in,
   output logic [7:0] rd8_out,
   output logic [15:0] rd16_out
);
   logic [7:0] regs_q [8];

   // Pair n is bytes 2n (low) and 2n+1 (high)
   assign rd8_out = regs_q[rd8_idx_in];
   assign rd16_out = {regs_q[{rd16_idx_in, 1'b1}], regs_q[{rd16_idx_in, 1'b0}]};

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < 8; i++) regs_q[i] <= 8'h00;
      end else if (wr_in.we16) begin
         regs_q[{wr_in.idx16, 1'b0}] <= wr_in.d16[7:0];
         regs_q[{wr_in.idx16, 1'b1}] <= wr_in.d16[15:8];
      end else if (wr_in.we8) begin
         regs_q[wr_in.idx8] <= wr_in.d8;
      end
   end
endmodule // gpr_bank
`default_nettype wire

// ---- tb/vec_mem_model.sv ----
// Byte memory that answers the register file's vector fetch reads.
// Assumes reads are answered in the cycle the address is shown.
`timescale 1ns/1ps
`default_nettype none
module vec_mem_model #(
   parameter logic [15:0] BOOT_VEC = 16'h1234
)(
   input wire logic clk_in,
   input wire logic rd_in,
   input wire logic [15:0] addr_in,
   output logic [7:0] rdata_out
);
   logic [7:0] last_q = 8'h5a;
   logic [7:0] byte_w;
   // Low byte at the even address, high byte at the odd one
   assign byte_w = (addr_in == 16'h0000) ? BOOT_VEC[7:0] : (addr_in == 16'h0001) ? BOOT_VEC[15:8] : ~addr_in[7:0];
   // Idle bus shows the inverted last byte, so stale data never passes
   assign rdata_out = rd_in ? byte_w : ~last_q;
   always_ff @(posedge clk_in) begin
      if (rd_in) begin
         last_q <= byte_w;
      end
   end
endmodule // vec_mem_model
`default_nettype wire

// ---- tb/cpu_control_register_file_tb.sv ----
// Self-checking bench for the core control register file.
// Assumes the vector memory model answers boot reads.
`timescale 1ns/1ps
`default_nettype none
module cpu_control_register_file_tb
   import cpu_regs_pkg::*;
;
   typedef struct {int id; logic [15:0] exp; int due;} note_t;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   ip_cmd_t ip_cmd = IP_HOLD;
   logic [2:0] ip_len = 3'h0;
   logic [15:0] ip_ld = 16'h0000;
   logic [4:0] tidx = 5'h00;
   logic mem_rd;
   logic [15:0] mem_addr;
   logic [7:0] mem_rdata;
   flag_upd_t fupd = '0;
   logic ack = 1'b0;
   logic pend = 1'b0;
   logic nmi = 1'b0;
   sp_cmd_t sp_cmd = SP_HOLD;
   logic [15:0] sp_ld = 16'h0000;
   gpr_wr_t gwr = '0;
   logic [2:0] rd8i = 3'h0;
   logic [1:0] rd16i = 2'h0;
   logic [15:0] aaddr = 16'h0000;
   logic [1:0] awid = 2'h0;
   logic [2:0] amask = 3'h0;
   logic [15:0] ip, sp, saddr, rd16;
   logic [7:0] flags, rd8;
   logic fault, take, refused, ready;
   region_t reg_o;
   note_t notes[$];
   note_t n;
   int cyc = 0;
   int error_cnt = 0;
   int comparisons = 0;
   int i;
   logic [31:0] rs = 32'h18;
   logic [31:0] r;
   logic [15:0] exp_ip;
   logic [7:0] regs [8];
   string nm [13] = '{"pointer", "flags", "stack", "stack_addr", "fault", "take", "rd8", "rd16", "region",
      "refused", "mem_addr", "mem_rd", "ready"};
   logic [15:0] ra [10] = '{16'h0040, 16'h007f, 16'h0080, 16'hfcff, 16'hfd00, 16'hfeff, 16'hff00, 16'hff02,
      16'hff03, 16'hffff};
   // Region in bits 6:4 as tcall, hram, periph; refusal in bit 0
   logic [6:0] rt [10] = '{7'h40, 7'h40, 7'h00, 7'h00, 7'h20, 7'h20, 7'h11, 7'h10, 7'h11, 7'h10};

   cpu_control_register_file #(.HRAM_BYTES(512)) uut (.clk_in(clk), .resetn_in(resetn), .ip_cmd_in(ip_cmd),
      .ip_len_in(ip_len), .ip_load_in(ip_ld), .tcall_idx_in(tidx), .mem_rd_out(mem_rd), .mem_addr_out(mem_addr),
      .mem_rdata_in(mem_rdata), .flag_upd_in(fupd), .irq_ack_in(ack), .irq_pending_in(pend), .irq_nmi_in(nmi),
      .sp_cmd_in(sp_cmd), .sp_load_in(sp_ld), .gpr_wr_in(gwr), .gpr_rd8_idx_in(rd8i), .gpr_rd16_idx_in(rd16i),
      .acc_addr_in(aaddr), .acc_width_in(awid), .periph_width_ok_in(amask), .next_instr_pointer_out(ip),
      .status_flag_word_out(flags), .stack_top_pointer_out(sp), .stack_addr_out(saddr), .sp_fault_out(fault),
      .irq_take_out(take), .gpr_rd8_out(rd8), .gpr_rd16_out(rd16), .acc_region_out(reg_o),
      .acc_refused_out(refused), .ready_out(ready));
   vec_mem_model mem (.clk_in(clk), .rd_in(mem_rd), .addr_in(mem_addr), .rdata_out(mem_rdata));

   ////////////////////////////////////////
   initial begin
      forever #2.5 clk = ~clk;
   end
   // Cycle ceiling well above the planned sequence
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 2000) begin
         error_cnt++;
         results();
      end
   end
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   function automatic logic [15:0] obs(input int id);
      case (id)
         0: obs = ip;
         1: obs = {8'h00, flags};
         2: obs = sp;
         3: obs = saddr;
         4: obs = {15'h0000, fault};
         5: obs = {15'h0000, take};
         6: obs = {8'h00, rd8};
         7: obs = rd16;
         8: obs = {13'h0000, reg_o};
         9: obs = {15'h0000, refused};
         10: obs = mem_addr;
         11: obs = {15'h0000, mem_rd};
         default: obs = {15'h0000, ready};
      endcase
   endfunction
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Latency counts edges from the driving edge to the settled output
   task automatic note(input int id, input logic [15:0] exp, input int lat);
      notes.push_back('{id, exp, cyc + lat});
   endtask
   always @(negedge clk) begin
      while (notes.size() > 0 && notes[0].due <= cyc) begin
         n = notes.pop_front();
         chk(nm[n.id], obs(n.id), n.exp);
      end
   end
   task automatic tick();
      @(posedge clk);
      ip_cmd <= IP_HOLD;
      sp_cmd <= SP_HOLD;
      fupd <= '0;
      ack <= 1'b0;
      pend <= 1'b0;
      nmi <= 1'b0;
      gwr <= '0;
   endtask
   task automatic fop(input flag_upd_t u, input logic p, input logic m, input logic a, input logic [7:0] ef,
      input logic et);
      @(posedge clk);
      fupd <= u;
      pend <= p;
      nmi <= m;
      ack <= a;
      note(1, {8'h00, ef}, 2);
      note(5, {15'h0000, et}, 2);
      tick();
   endtask
   task automatic spop(input sp_cmd_t c, input logic [15:0] ld, input logic [15:0] es, input logic [15:0] ea,
      input logic ef);
      @(posedge clk);
      sp_cmd <= c;
      sp_ld <= ld;
      note(2, es, 2);
      if (c != SP_LOAD) begin
         note(3, ea, 2);
         note(4, {15'h0000, ef}, 2);
      end
      tick();
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   ////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      note(1, 16'h0002, 0);
      note(10, VEC_RESET_LO, 0);
      note(11, 16'h0001, 0);
      resetn <= 1'b1;
      note(10, VEC_RESET_HI, 2);
      note(11, 16'h0001, 2);
      note(12, 16'h0000, 2);
      note(12, 16'h0001, 3);
      exp_ip = 16'h1234;
      note(0, exp_ip, 3);
      note(1, 16'h0002, 3);
      repeat (2) @(posedge clk);
      $display("test boot done");
      for (i = 0; i < 5; i++) begin
         r = rnd();
         @(posedge clk);
         ip_cmd <= (i == 4) ? IP_LOAD : IP_ADVANCE;
         ip_len <= 3'(i + 1);
         ip_ld <= r[15:0];
         exp_ip = (i == 4) ? r[15:0] : exp_ip + 16'(i + 1);
         note(0, exp_ip, 2);
         tick();
      end
      @(posedge clk);
      ip_cmd <= IP_TABLE;
      tidx <= 5'h1f;
      note(10, 16'h007e, 2);
      note(11, 16'h0001, 2);
      tick();
      $display("test pointer done");
      r = rnd();
      fop(17'h00100 | 17'(r[7:0]), 0, 0, 0, (r[7:0] & 8'hd1) | 8'h02, 0);
      fop(17'h00100, 0, 0, 0, 8'h02, 0);
      fop(17'h00200, 0, 0, 0, 8'h82, 0);
      fop(17'h00000, 1, 0, 0, 8'h82, 1);
      fop(17'h00000, 0, 0, 1, 8'h02, 0);
      fop(17'h00000, 1, 0, 0, 8'h02, 0);
      fop(17'h00000, 0, 1, 0, 8'h02, 1);
      fop(17'h00600, 0, 0, 0, 8'h02, 0);
      fop(17'h18000, 0, 0, 0, 8'h42, 0);
      fop(17'h06000, 0, 0, 0, 8'h52, 0);
      fop(17'h01800, 0, 0, 0, 8'h53, 0);
      fop(17'h11000, 0, 0, 0, 8'h12, 0);
      $display("test flags done");
      spop(SP_LOAD, 16'hfe00, 16'hfe00, 16'h0000, 0);
      spop(SP_PUSH, 16'h0000, 16'hfdff, 16'hfdff, 0);
      spop(SP_PUSH, 16'h0000, 16'hfdfe, 16'hfdfe, 0);
      spop(SP_POP, 16'h0000, 16'hfdff, 16'hfdfe, 0);
      spop(SP_POP, 16'h0000, 16'hfe00, 16'hfdff, 0);
      spop(SP_LOAD, 16'hfd01, 16'hfd01, 16'h0000, 0);
      spop(SP_PUSH, 16'h0000, 16'hfd00, 16'hfd00, 0);
      spop(SP_PUSH, 16'h0000, 16'hfcff, 16'hfcff, 1);
      $display("test stack done");
      for (i = 0; i < 9; i++) begin
         r = rnd();
         @(posedge clk);
         // Last pass writes a pair and a byte at once; the pair wins
         gwr.we8 <= 1'b1;
         gwr.idx8 <= (i == 8) ? 3'h6 : 3'(i);
         gwr.d8 <= r[23:16];
         gwr.we16 <= (i == 8);
         gwr.idx16 <= 2'h3;
         gwr.d16 <= r[15:0];
         if (i == 8) {regs[7], regs[6]} = r[15:0];
         else regs[i] = r[23:16];
         tick();
      end
      for (i = 0; i < 8; i++) begin
         @(posedge clk);
         rd8i <= 3'(i);
         rd16i <= 2'(i / 2);
         note(6, {8'h00, regs[i]}, 2);
         note(7, {regs[i | 1], regs[i & 6]}, 2);
      end
      $display("test registers done");
      for (i = 0; i < 10; i++) begin
         @(posedge clk);
         aaddr <= ra[i];
         awid <= (i == 3 || i == 7 || i == 8) ? 2'h2 : ((i == 9) ? 2'h0 : 2'h1);
         amask <= (i == 6) ? 3'h5 : 3'h7;
         note(8, {13'h0000, rt[i][6:4]}, 2);
         note(9, {15'h0000, rt[i][0]}, 2);
      end
      $display("test regions done");
      repeat (4) @(posedge clk);
      results();
   end
endmodule // cpu_control_register_file_tb
`default_nettype wire
